// ==== verilog/rtc_core.sv ====
// Purpose: temperature compensation of the filtered rate and its parameter words
// Assumes: one rate sample is not offered while a compensation is running
// Notes: compensated samples appear 64 cycles after acceptance
`timescale 1ns/1ps

module rtc_core (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // parameter access
  input wire logic [5:0] i_addr,
  input wire logic i_sys_wr,
  input wire logic i_sys_rd,
  input wire logic i_nv_wr,
  input wire logic i_nv_rd,
  input wire logic [31:0] i_wdata,
  input wire logic i_store_clear,
  output logic [31:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_busy,
  // sensor samples
  input wire logic i_rate_valid,
  input wire logic [23:0] i_rate_raw,
  input wire logic [11:0] i_temp_raw,
  // outputs
  output logic [23:0] o_rate,
  output logic o_rate_valid,
  output logic [15:0] o_temp
);

  // ****************************************************************
  // volatile parameter words
  // ****************************************************************
  logic [31:0] vol_q [rtc_pkg::NREG];
  logic [31:0] rd_mask [rtc_pkg::NREG];
  logic [31:0] sys_word;
  logic [31:0] store_rdata;
  logic [3:0] boot_cnt_q;
  logic [3:0] ld_idx_q;
  logic ld_q;
  logic busy_q;
  logic [7:0] slot_boot_q;
  logic nv_rd_q;
  wire boot_issue = busy_q && (boot_cnt_q < 4'(rtc_pkg::NREG));
  wire host_ok = !busy_q;
  wire [5:0] boot_addr = rtc_pkg::REG_ADDR_LIST[boot_cnt_q*6 +: 6];
  wire [5:0] store_addr = busy_q ? boot_addr : i_addr;
  wire coef_word = (i_addr == rtc_pkg::ADDR_RATE_SEL) || (i_addr >= rtc_pkg::ADDR_SECOND
    && i_addr <= rtc_pkg::ADDR_TEMPERATURE_MIDPOINT);
  wire slots_full = (slot_boot_q == rtc_pkg::SLOT_FULL);
  wire store_we = i_nv_wr && host_ok && !(coef_word && slots_full);

  generate
    for (genvar i = 0; i < rtc_pkg::NREG; i++) begin : g_reg
      wire hit = (i_addr == rtc_pkg::REG_ADDR_LIST[i*6 +: 6]);
      wire boot_ld = ld_q && (ld_idx_q == 4'(i));
      assign rd_mask[i] = hit ? vol_q[i] : 32'h00000000;
      // store writes never reach this word until the next boot load
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          vol_q[i] <= rtc_pkg::REG_RESET_LIST[i*32 +: 32];
        end else if (boot_ld) begin
          vol_q[i] <= store_rdata;
        end else if (i_sys_wr && host_ok && hit) begin
          vol_q[i] <= i_wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    sys_word = 32'h00000000;
    for (int k = 0; k < rtc_pkg::NREG; k++) begin
      sys_word = sys_word | rd_mask[k];
    end
  end

  rtc_nv_store u_store (
    .i_core_clk(i_core_clk),
    .i_clear(i_store_clear),
    .i_addr(store_addr),
    .i_we(store_we),
    .i_wdata(i_wdata),
    .o_rdata(store_rdata)
  );

  // ****************************************************************
  // boot load and host answers
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_q <= 1'b1;
      boot_cnt_q <= 4'h0;
      ld_q <= 1'b0;
      ld_idx_q <= 4'h0;
    end else begin
      ld_q <= boot_issue;
      ld_idx_q <= boot_cnt_q;
      if (boot_issue) begin
        boot_cnt_q <= boot_cnt_q + 4'h1;
      end
      if (ld_q && ld_idx_q == 4'(rtc_pkg::NREG - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // pass budget is frozen at boot so a volatile edit cannot unlock the store
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      slot_boot_q <= rtc_pkg::SLOT_RESET;
    end else if (ld_q && ld_idx_q == 4'(rtc_pkg::IDX_RATE_SEL)) begin
      slot_boot_q <= store_rdata[rtc_pkg::SLOT_LSB +: 8];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      nv_rd_q <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rdata_valid <= 1'b0;
    end else begin
      nv_rd_q <= i_nv_rd && host_ok;
      o_rdata_valid <= nv_rd_q || (i_sys_rd && host_ok);
      if (nv_rd_q) begin
        o_rdata <= store_rdata;
      end else if (i_sys_rd && host_ok) begin
        o_rdata <= sys_word;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_busy <= 1'b1;
    end else begin
      o_busy <= busy_q;
    end
  end

  // ****************************************************************
  // temperature output
  // ****************************************************************
  wire temp_cal_sel = vol_q[rtc_pkg::IDX_TEMP_SEL][rtc_pkg::TEMP_SEL_BIT];
  wire [11:0] toff = vol_q[rtc_pkg::IDX_TEMP_CAL][rtc_pkg::TOFF_LSB +: 12];
  wire [11:0] tgain = vol_q[rtc_pkg::IDX_TEMP_CAL][rtc_pkg::TGAIN_LSB +: 12];
  wire [23:0] tprod = tgain * i_temp_raw;
  wire [15:0] temp_cal = 16'(tprod >> rtc_pkg::GAIN_FRAC) + {4'h0, toff};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_temp <= 16'h0000;
    end else begin
      o_temp <= temp_cal_sel ? temp_cal : {4'h0, i_temp_raw};
    end
  end

  // ****************************************************************
  // compensation datapath
  // ****************************************************************
  rtc_pkg::rtc_state_type state_q;
  logic signed [23:0] raw_q;
  logic signed [20:0] dt_q;
  logic [61:0] quo_q;
  logic [34:0] rem_q;
  logic [34:0] den_q;
  logic neg_q;
  logic [5:0] step_q;
  wire bypass = vol_q[rtc_pkg::IDX_RATE_SEL][rtc_pkg::RATE_BYPASS_BIT];
  wire take = i_rate_valid && host_ok && state_q == rtc_pkg::CS_IDLE;
  wire [19:0] temperature_midpoint = vol_q[rtc_pkg::IDX_TEMPERATURE_MIDPOINT][19:0];
  wire signed [20:0] dt_d = $signed({1'b0, i_temp_raw, 8'h00}) - $signed({1'b0, temperature_midpoint});
  wire signed [15:0] b2 = vol_q[rtc_pkg::IDX_SECOND][15:0];
  wire signed [29:0] b1 = vol_q[rtc_pkg::IDX_BIAS1][29:0];
  wire signed [29:0] b0 = vol_q[rtc_pkg::IDX_BIAS0][29:0];
  wire signed [15:0] sf2 = vol_q[rtc_pkg::IDX_SECOND][rtc_pkg::SCALE2_LSB +: 16];
  wire signed [29:0] sf1 = vol_q[rtc_pkg::IDX_SCALE1][29:0];
  wire signed [29:0] sf0 = vol_q[rtc_pkg::IDX_SCALE0][29:0];
  wire signed [41:0] dt2 = dt_q * dt_q;
  wire signed [57:0] b2t = b2 * dt2;
  wire signed [50:0] b1t = b1 * dt_q;
  wire signed [57:0] sf2t = sf2 * dt2;
  wire signed [50:0] sf1t = sf1 * dt_q;
  // fixed-point scalings undo the stored pre-scale of b1, b2, sf1 and sf2; b0 and sf0 are added unshifted
  wire signed [34:0] bias_w = 35'(b0) + 35'(b1t >>> rtc_pkg::B1_SHIFT)
    + 35'(b2t >>> rtc_pkg::B2_SHIFT);
  wire signed [34:0] den_w = 35'(sf0) + 35'(sf1t >>> rtc_pkg::SF1_SHIFT)
    + 35'(sf2t >>> rtc_pkg::SF2_SHIFT);
  wire signed [34:0] num_w = 35'(raw_q) - bias_w;
  wire [34:0] num_mag = num_w[34] ? 35'(-num_w) : num_w;
  wire [34:0] den_mag = den_w[34] ? 35'(-den_w) : den_w;
  wire [35:0] shifted = {rem_q, quo_q[61]};
  wire [36:0] trial = {1'b0, shifted} - {2'b00, den_q};
  wire pos_ovf = |quo_q[61:23];
  wire neg_ovf = (|quo_q[61:24]) || (quo_q[23] && |quo_q[22:0]);
  wire div_zero = (den_q == 35'h000000000);
  wire [23:0] sat_w = neg_q ? ((neg_ovf || div_zero) ? 24'h800000 : 24'(-quo_q[23:0]))
    : ((pos_ovf || div_zero) ? 24'h7fffff : quo_q[23:0]);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= rtc_pkg::CS_IDLE;
      step_q <= 6'h00;
    end else begin
      case (state_q)
        rtc_pkg::CS_IDLE: if (take && !bypass) state_q <= rtc_pkg::CS_PREP;
        rtc_pkg::CS_PREP: begin
          state_q <= rtc_pkg::CS_DIV;
          step_q <= 6'h00;
        end
        rtc_pkg::CS_DIV: begin
          step_q <= step_q + 6'h01;
          if (step_q == rtc_pkg::DIV_LAST) state_q <= rtc_pkg::CS_DONE;
        end
        rtc_pkg::CS_DONE: state_q <= rtc_pkg::CS_IDLE;
        default: state_q <= rtc_pkg::CS_IDLE;
      endcase
    end
  end

  // numerator carries the 2^27 that cancels the scale-constant pre-scale
  always_ff @(posedge i_core_clk) begin
    if (take) begin
      raw_q <= i_rate_raw;
      dt_q <= dt_d;
    end
    if (state_q == rtc_pkg::CS_PREP) begin
      quo_q <= {num_mag, 27'h0000000};
      rem_q <= 35'h000000000;
      den_q <= den_mag;
      neg_q <= num_w[34] ^ den_w[34];
    end else if (state_q == rtc_pkg::CS_DIV) begin
      rem_q <= trial[36] ? shifted[34:0] : trial[34:0];
      quo_q <= {quo_q[60:0], !trial[36]};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rate <= 24'h000000;
      o_rate_valid <= 1'b0;
    end else begin
      o_rate_valid <= (take && bypass) || state_q == rtc_pkg::CS_DONE;
      if (take && bypass) begin
        o_rate <= i_rate_raw;
      end else if (state_q == rtc_pkg::CS_DONE) begin
        o_rate <= sat_w;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_bypass_raw_out: assert property (take && bypass |=> o_rate_valid && o_rate == $past(i_rate_raw))
    else $error("bypass sample not passed raw");
  a_comp_latency: assert property (take && !bypass |-> ##65 o_rate_valid)
    else $error("compensated sample late or missing");
  a_comp_quiet: assert property (take && !bypass |=> !o_rate_valid [*8])
    else $error("compensated sample too early");
  a_temp_raw_sel: assert property (!temp_cal_sel |=> o_temp == {4'h0, $past(i_temp_raw)})
    else $error("raw temperature not selected");
  a_temp_cal_sel: assert property (temp_cal_sel && tgain == 12'h800 && toff == 12'h000
    |=> o_temp == {2'b00, $past(i_temp_raw), 2'b00})
    else $error("calibrated temperature wrong");
  a_sys_read_lat: assert property (i_sys_rd && host_ok && !nv_rd_q |=> o_rdata_valid && o_rdata == $past(sys_word))
    else $error("system read answer wrong");
  a_nv_read_lat: assert property (i_nv_rd && host_ok |-> ##2 o_rdata_valid)
    else $error("store read answer missing");
  a_slot_refuse: assert property (i_nv_wr && coef_word && slots_full |-> !store_we)
    else $error("store written with no slot left");
  a_boot_busy: assert property ($fell(busy_q) |-> $past(ld_q) && $past(ld_idx_q) == 4'(rtc_pkg::NREG - 1))
    else $error("boot ended before last word");
  a_busy_silent: assert property (busy_q |=> !o_rate_valid)
    else $error("rate produced during boot");
  a_sat_bounds: assert property (state_q == rtc_pkg::CS_DONE && !neg_q && pos_ovf |=> o_rate == 24'h7fffff)
    else $error("positive overflow not saturated");

  c_bypass: cover property (take && bypass);
  c_comp: cover property (state_q == rtc_pkg::CS_DONE);
  c_temp_cal: cover property (temp_cal_sel && i_sys_rd);
  c_refuse: cover property (i_nv_wr && coef_word && slots_full);

endmodule // rtc_core

// ==== include/rtc_pkg.sv ====
// Purpose: shared constants for the rate temperature compensation block
// Assumes: word addresses are shared by the volatile registers and the store
// Notes: field positions, reset values and timing counts live here; the core hard-codes the 8-bit temperature and 27-bit numerator shifts
package rtc_pkg;

  // ****************************************************************
  // word addresses and register list
  // ****************************************************************
  localparam int NREG = 10;
  localparam logic [5:0] ADDR_SERIAL = 6'h00;
  localparam logic [5:0] ADDR_RATE_SEL = 6'h02;
  localparam logic [5:0] ADDR_TEMP_CAL = 6'h04;
  localparam logic [5:0] ADDR_TEMP_SEL = 6'h09;
  localparam logic [5:0] ADDR_SECOND = 6'h2e;
  localparam logic [5:0] ADDR_BIAS1 = 6'h2f;
  localparam logic [5:0] ADDR_BIAS0 = 6'h30;
  localparam logic [5:0] ADDR_SCALE1 = 6'h31;
  localparam logic [5:0] ADDR_SCALE0 = 6'h32;
  localparam logic [5:0] ADDR_TEMPERATURE_MIDPOINT = 6'h33;
  localparam logic [NREG*6-1:0] REG_ADDR_LIST = {ADDR_TEMPERATURE_MIDPOINT, ADDR_SCALE0, ADDR_SCALE1, ADDR_BIAS0,
    ADDR_BIAS1, ADDR_SECOND, ADDR_TEMP_SEL, ADDR_TEMP_CAL, ADDR_RATE_SEL, ADDR_SERIAL};
  localparam int IDX_RATE_SEL = 1;
  localparam int IDX_TEMP_CAL = 2;
  localparam int IDX_TEMP_SEL = 3;
  localparam int IDX_SECOND = 4;
  localparam int IDX_BIAS1 = 5;
  localparam int IDX_BIAS0 = 6;
  localparam int IDX_SCALE1 = 7;
  localparam int IDX_SCALE0 = 8;
  localparam int IDX_TEMPERATURE_MIDPOINT = 9;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TEMP_SEL_BIT = 2;
  localparam int RATE_BYPASS_BIT = 27;
  localparam int TOFF_LSB = 16;
  localparam int TGAIN_LSB = 2;
  localparam int SLOT_LSB = 8;
  localparam int SCALE2_LSB = 16;
  localparam int GAIN_FRAC = 9;
  localparam int TEMP_SCALE_SHIFT = 8;
  localparam int B1_SHIFT = 35;
  localparam int B2_SHIFT = 39;
  localparam int SF1_SHIFT = 19;
  localparam int SF2_SHIFT = 28;
  localparam int SF0_SHIFT = 27;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [11:0] TOFF_RESET = 12'h000;
  localparam logic [11:0] TGAIN_RESET = 12'h800;
  localparam logic [7:0] SLOT_RESET = 8'h01;
  localparam logic [7:0] SLOT_FULL = 8'hff;
  localparam int OUT_SCALE_CPDS = 10000;
  localparam logic [31:0] WORD2_RESET = {24'h000000, SLOT_RESET} << SLOT_LSB;
  localparam logic [31:0] WORD4_RESET = ({20'h00000, TOFF_RESET} << TOFF_LSB) | ({20'h00000, TGAIN_RESET} << TGAIN_LSB);
  localparam logic [NREG*32-1:0] REG_RESET_LIST = {224'h0, WORD4_RESET, WORD2_RESET, 32'h00000000};
  localparam int DIV_STEPS = 62;
  localparam logic [5:0] DIV_LAST = 6'h3d;

  typedef enum {CS_IDLE, CS_PREP, CS_DIV, CS_DONE} rtc_state_type;

  function automatic logic [31:0] default_word(input logic [5:0] addr);
    logic [31:0] w;
    w = 32'h00000000;
    for (int k = 0; k < NREG; k++) begin
      if (REG_ADDR_LIST[k*6 +: 6] == addr) begin
        w = REG_RESET_LIST[k*32 +: 32];
      end
    end
    return w;
  endfunction

endpackage

// ==== verilog/rtc_nv_store.sv ====
// Purpose: nonvolatile parameter store, 64 words of 32 bits
// Assumes: i_rst of the block does not touch the contents
// Notes: an unprogrammed word reads as its factory default
`timescale 1ns/1ps
module rtc_nv_store (
  // clock
  input wire logic i_core_clk,
  // blanking of the whole store
  input wire logic i_clear,
  // access port
  input wire logic [5:0] i_addr,
  input wire logic i_we,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);

  logic [31:0] mem_q [64];
  logic [63:0] prog_q;

  // contents survive the block reset on purpose
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      prog_q <= 64'h0000000000000000;
    end else if (i_we) begin
      prog_q[i_addr] <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rdata <= prog_q[i_addr] ? mem_q[i_addr] : rtc_pkg::default_word(i_addr);
  end

endmodule // rtc_nv_store

// ==== sim/rtc_host_model.sv ====
// Purpose: host side of the parameter access port
// Assumes: strobes launched on the falling clock edge
// Notes: every field update is a whole-word read-modify-write
`timescale 1ns/1ps
module rtc_host_model (
  // clock
  input wire logic i_core_clk,
  // access strobes
  output logic [5:0] o_addr,
  output logic o_sys_wr,
  output logic o_sys_rd,
  output logic o_nv_wr,
  output logic o_nv_rd,
  output logic [31:0] o_wdata,
  // answer
  input wire logic [31:0] i_rdata,
  input wire logic i_rdata_valid
);
  initial begin
    o_addr = 6'h00;
    {o_sys_wr, o_sys_rd, o_nv_wr, o_nv_rd} = 4'h0;
    o_wdata = 32'h00000000;
  end

  // ****************************************************************
  // one strobe, held across exactly one rising edge
  // ****************************************************************
  task automatic strobe(input logic [5:0] addr, input logic [31:0] data, input logic [3:0] kind);
    @(negedge i_core_clk);
    o_addr = addr;
    o_wdata = data;
    {o_sys_wr, o_sys_rd, o_nv_wr, o_nv_rd} = kind;
    @(negedge i_core_clk);
    {o_sys_wr, o_sys_rd, o_nv_wr, o_nv_rd} = 4'h0;
    // released data lines never show the old word
    o_wdata = ~data;
  endtask

  task automatic read(input logic [5:0] addr, input logic nv, output logic [31:0] data);
    int n;
    n = 0;
    strobe(addr, 32'h00000000, nv ? 4'h1 : 4'h4);
    while (i_rdata_valid !== 1'b1 && n < 4) begin
      @(negedge i_core_clk);
      n++;
    end
    data = (n == 4) ? 32'hxxxxxxxx : i_rdata;
  endtask

  // other bits of the word are carried over untouched
  task automatic rmw(input logic [5:0] addr, input logic [31:0] mask, input logic [31:0] val, input logic nv);
    logic [31:0] w;
    read(addr, nv, w);
    w = (w & ~mask) | (val & mask);
    strobe(addr, w, nv ? 4'h2 : 4'h8);
  endtask

  // raw rate is wanted while acquiring calibration data
  task automatic set_bypass(input logic on);
    rmw(6'h02, 32'h08000000, {4'h0, on, 27'h0}, 1'b0);
  endtask
endmodule // rtc_host_model

// ==== sim/rate_temp_compensation_test.sv ====
// Purpose: self-checking bench of the rate compensation core
// Assumes: store blanked once at start, host model owns the access port
// Notes: expectations are worked out by hand from the field layout
`timescale 1ns/1ps
module rate_temp_compensation_test;
  logic clk, rst, store_clear, rate_valid, sys_wr, sys_rd, nv_wr, nv_rd, rdata_valid, busy, o_rate_valid;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [23:0] rate_raw, rate;
  logic [11:0] temp_raw;
  logic [15:0] temp;
  int failures = 0;
  int n_compared = 0;

  rtc_core i_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_sys_wr(sys_wr), .i_sys_rd(sys_rd),
    .i_nv_wr(nv_wr), .i_nv_rd(nv_rd), .i_wdata(wdata), .i_store_clear(store_clear), .o_rdata(rdata),
    .o_rdata_valid(rdata_valid), .o_busy(busy), .i_rate_valid(rate_valid), .i_rate_raw(rate_raw),
    .i_temp_raw(temp_raw), .o_rate(rate), .o_rate_valid(o_rate_valid), .o_temp(temp));
  rtc_host_model i_host (.i_core_clk(clk), .o_addr(addr), .o_sys_wr(sys_wr), .o_sys_rd(sys_rd),
    .o_nv_wr(nv_wr), .o_nv_rd(nv_rd), .o_wdata(wdata), .i_rdata(rdata), .i_rdata_valid(rdata_valid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset();
    int n;
    n = 0;
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check({31'h0, busy}, 32'h1);
    rst = 1'b0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, busy}, 32'h0);
  endtask

  task automatic sample(input logic [23:0] raw, output int lat);
    @(negedge clk);
    rate_raw = raw;
    rate_valid = 1'b1;
    @(negedge clk);
    rate_valid = 1'b0;
    rate_raw = ~raw;
    lat = 0;
    while (o_rate_valid !== 1'b1 && lat < 80) begin
      @(negedge clk);
      lat++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    logic [31:0] w;
    for (int s = 0; s < 2; s++) begin
      i_host.read(6'h02, s[0], w);
      check(w, 32'h00000100);
      i_host.read(6'h04, s[0], w);
      check(w, 32'h00002000);
      i_host.read(6'h09, s[0], w);
      check(w, 32'h00000000);
    end
    i_host.read(6'h01, 1'b0, w);
    check(w, 32'h00000000);
  endtask

  task automatic t_temp();
    logic [31:0] w;
    temp_raw = 12'h123;
    repeat (2) @(negedge clk);
    check({16'h0, temp}, 32'h00000123);
    i_host.rmw(6'h04, 32'h0fff3ffc, 32'h00101000, 1'b0);
    i_host.read(6'h04, 1'b0, w);
    check(w, 32'h00101000);
    i_host.rmw(6'h09, 32'h00000004, 32'h00000004, 1'b0);
    repeat (2) @(negedge clk);
    // gain 0x400 is 2.0 with nine fraction bits, offset 0x010
    check({16'h0, temp}, ((32'h400 * 32'h123) >> 9) + 32'h10);
    // back to unity-times-four gain, zero offset
    i_host.rmw(6'h04, 32'h0fff3ffc, 32'h00002000, 1'b0);
    repeat (2) @(negedge clk);
    check({16'h0, temp}, 32'h0000048c);
    i_host.rmw(6'h09, 32'h00000004, 32'h00000000, 1'b0);
    repeat (2) @(negedge clk);
    check({16'h0, temp}, 32'h00000123);
  endtask

  task automatic t_bypass();
    int lat;
    i_host.set_bypass(1'b1);
    sample(24'h812345, lat);
    // counted from the falling edge after acceptance: raw is already out there
    check(lat, 32'd0);
    check({8'h0, rate}, 32'h00812345);
    i_host.set_bypass(1'b0);
  endtask

  task automatic t_comp();
    logic [5:0] a [6] = '{6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33};
    logic [31:0] m [6] = '{32'hffffffff, 32'h3fffffff, 32'h3fffffff, 32'h3fffffff, 32'h3fffffff, 32'h000fffff};
    logic [31:0] v [6] = '{32'h00042000, 32'h00c00000, 32'h00000064, 32'h00000040, 32'h07fffffe, 32'h00001000};
    int lat;
    // dt = 0x30*256 - 0x1000 = 2^13: bias 100+3+1, den (2^27-2)+1+1
    temp_raw = 12'h030;
    for (int k = 0; k < 6; k++) begin
      i_host.rmw(a[k], m[k], v[k], 1'b0);
    end
    sample(24'd1104, lat);
    check(lat, 32'd64);
    check({8'h0, rate}, 32'd1000);
    // den halves to 2^26, so the output doubles and clips
    i_host.rmw(6'h32, 32'h3fffffff, 32'h03fffffe, 1'b0);
    sample(24'h7fff00, lat);
    check({8'h0, rate}, 32'h007fffff);
    sample(24'h800100, lat);
    check({8'h0, rate}, 32'h00800000);
  endtask

  task automatic t_store();
    logic [31:0] w;
    i_host.rmw(6'h30, 32'h3fffffff, 32'h00000055, 1'b1);
    i_host.read(6'h30, 1'b1, w);
    check(w, 32'h00000055);
    i_host.read(6'h30, 1'b0, w);
    check(w, 32'h00000064);
    do_reset();
    i_host.read(6'h30, 1'b0, w);
    check(w, 32'h00000055);
    // last slot used: further coefficient programming must be dropped
    i_host.rmw(6'h02, 32'h0000ff00, 32'h0000ff00, 1'b1);
    do_reset();
    i_host.read(6'h02, 1'b0, w);
    check(w, 32'h0000ff00);
    i_host.rmw(6'h30, 32'h3fffffff, 32'h00000077, 1'b1);
    i_host.read(6'h30, 1'b1, w);
    check(w, 32'h00000055);
  endtask

  initial begin
    rst = 1'b1;
    store_clear = 1'b1;
    rate_valid = 1'b0;
    rate_raw = 24'h000000;
    temp_raw = 12'h000;
    repeat (2) @(negedge clk);
    store_clear = 1'b0;
    do_reset();
    t_defaults();
    t_temp();
    t_bypass();
    t_comp();
    t_store();
    results();
  end

  // hang guard, roughly fifty times the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule // rate_temp_compensation_test
